// File: inc/srh_defs.vh
// Purpose: constants for the status reporting hierarchy
// Assumes: 250 MHz clock
// Notes: bit positions of status byte and device condition register
`ifndef SRH_DEFS_VH
`define SRH_DEFS_VH
`define SRH_STB_DEV 1
`define SRH_STB_ERRQ 2
`define SRH_STB_QUES 3
`define SRH_STB_MAV 4
`define SRH_STB_ESB 5
`define SRH_STB_RQS 6
`define SRH_STB_OPER 7
`define SRH_DEV_SUM 0
`define SRH_DEV_NOMEAS 1
`define SRH_DEV_BADRES 2
`define SRH_DEV_WARN 3
`define SRH_DEV_CRIT 4
`define SRH_CLK_MHZ 250
`define SRH_SLOW_MS 500
`define SRH_FAST_MS 125
`define SRH_SLOW_CYC (`SRH_SLOW_MS * `SRH_CLK_MHZ * 1000)
`define SRH_FAST_CYC (`SRH_FAST_MS * `SRH_CLK_MHZ * 1000)
`define SRH_W8_ZERO 8'h00
`define SRH_RQS_MASK 8'hbf
`define SRH_W16_ZERO 16'h0000
`endif

// File: hdl/srh_event_reg.v
// Purpose: sticky event register with enable mask and summary
// Assumes: condition is synchronous to clk_i
// Notes: set wins over a read-clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
module srh_event_reg #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // condition and control
    input wire [WIDTH-1:0] cond_i,
    input wire [WIDTH-1:0] enable_i,
    input wire rd_clr_i,
    // results
    output reg [WIDTH-1:0] event_o,
    output wire summary_o
);
    reg [WIDTH-1:0] cond_r;
    wire [WIDTH-1:0] rise;
    assign rise = cond_i & ~cond_r;
    // latch rising conditions; a read clears all but a fresh rise
    always @(posedge clk_i) begin
        if (rst_i) begin
            cond_r <= {WIDTH{1'b0}};
            event_o <= {WIDTH{1'b0}};
        end else begin
            cond_r <= cond_i;
            event_o <= (rd_clr_i ? {WIDTH{1'b0}} : event_o) | rise;
        end
    end
    assign summary_o = |(event_o & enable_i);
endmodule // srh_event_reg
`default_nettype wire

// File: hdl/srh_led_flash.v
// Purpose: red status indicator flash generator
// Assumes: one clock domain
// Notes: critical takes priority over warning
`timescale 1ns/100ps
`default_nettype none
`include "srh_defs.vh"
module srh_led_flash #(
    parameter SLOW_CYC = `SRH_SLOW_CYC,
    parameter FAST_CYC = `SRH_FAST_CYC
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // error categories
    input wire warn_i,
    input wire crit_i,
    // indicator
    output reg red_o
);
    reg [31:0] cnt_r;
    wire [31:0] half;
    assign half = crit_i ? FAST_CYC : SLOW_CYC;
    // toggle each half period while an error holds, dark otherwise
    always @(posedge clk_i) begin
        if (rst_i || !(warn_i || crit_i)) begin
            cnt_r <= 32'h00000000;
            red_o <= 1'b0;
        end else if (cnt_r >= half - 32'h00000001) begin
            cnt_r <= 32'h00000000;
            red_o <= ~red_o;
        end else begin
            cnt_r <= cnt_r + 32'h00000001;
        end
    end
endmodule // srh_led_flash
`default_nettype wire

// File: hdl/srh_status_top.v
// Purpose: status byte and device condition register of an instrument
// Assumes: all inputs come from logic on clk_i; host access by command strobes
// Notes: no bus; reads are strobes that clear sticky event registers
// Operation
// - status byte bit 1 summarises the device event register through its enable.
// - status byte bit 2 is one exactly while the error queue holds an entry.
// - with bit 2 enabled every new error queue entry pulses a service request.
// - status byte bit 3 is set when an enabled questionable event bit is set.
// - status byte bit 4 is set while a response message is waiting.
// - status byte bit 5 is set when an enabled standard event bit is set.
// - status byte bit 6 and a service request follow any enabled other bit.
// - status byte bit 7 is set when an enabled operation event bit is set.
// - the service request enable mask is writable and readable by the host.
// - device bit 0 is the OR of static error bits 1 to 4.
// - device bit 1 flags a static error making measurement impossible.
// - device bit 2 flags a static error making results possibly wrong.
// - device bit 3 flags a warning and flashes the indicator red slowly.
// - device bit 4 flags a critical error and flashes the indicator red fast.
// - the standard event enable mask is writable and readable by the host.
`timescale 1ns/100ps
`default_nettype none
`include "srh_defs.vh"
module srh_status_top #(
    parameter WIDTH = 16,
    parameter SLOW_CYC = `SRH_SLOW_CYC,
    parameter FAST_CYC = `SRH_FAST_CYC
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // static error categories
    input wire static_error_nomeas_i,
    input wire static_error_badres_i,
    input wire static_error_warn_i,
    input wire static_error_crit_i,
    // lower level conditions
    input wire [WIDTH-1:0] dev_cond_hi_i,
    input wire [WIDTH-1:0] ques_cond_i,
    input wire [WIDTH-1:0] oper_cond_i,
    input wire [7:0] std_event_i,
    input wire err_queue_push_i,
    input wire err_queue_not_empty_i,
    input wire msg_avail_i,
    // host enable writes
    input wire sre_wr_i,
    input wire ese_wr_i,
    input wire dev_en_wr_i,
    input wire ques_en_wr_i,
    input wire oper_en_wr_i,
    input wire [WIDTH-1:0] wr_data_i,
    // host event reads (clear on read)
    input wire dev_rd_i,
    input wire ques_rd_i,
    input wire oper_rd_i,
    input wire esr_rd_i,
    // read back
    output reg [7:0] status_byte_o,
    output reg [7:0] sre_o,
    output reg [7:0] ese_o,
    output reg [7:0] esr_o,
    output reg [WIDTH-1:0] dev_en_o,
    output reg [WIDTH-1:0] ques_en_o,
    output reg [WIDTH-1:0] oper_en_o,
    output wire [WIDTH-1:0] device_condition_status_o,
    output wire [WIDTH-1:0] dev_event_o,
    output wire [WIDTH-1:0] ques_event_o,
    output wire [WIDTH-1:0] oper_event_o,
    // service request and indicator
    output reg srq_o,
    output wire led_red_o
);
    wire [3:0] static_error;
    wire dev_sum;
    wire ques_sum;
    wire oper_sum;
    wire esb_sum;
    reg [7:0] stb_nxt;
    reg [7:0] other_bits;
    reg [7:0] srq_src_r;
    reg errq_push_r;

    // static error categories and their summary
    assign static_error = {static_error_crit_i, static_error_warn_i, static_error_badres_i,
                           static_error_nomeas_i};
    assign device_condition_status_o = {dev_cond_hi_i[WIDTH-1:5], static_error,
                                        |static_error};

    // host mask registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            sre_o <= `SRH_W8_ZERO;
            ese_o <= `SRH_W8_ZERO;
            dev_en_o <= `SRH_W16_ZERO;
            ques_en_o <= `SRH_W16_ZERO;
            oper_en_o <= `SRH_W16_ZERO;
        end else begin
            if (sre_wr_i) begin
                sre_o <= wr_data_i[7:0];
            end
            if (ese_wr_i) begin
                ese_o <= wr_data_i[7:0];
            end
            if (dev_en_wr_i) begin
                dev_en_o <= wr_data_i;
            end
            if (ques_en_wr_i) begin
                ques_en_o <= wr_data_i;
            end
            if (oper_en_wr_i) begin
                oper_en_o <= wr_data_i;
            end
        end
    end

    // standard event register: sticky, cleared by its read, set wins
    always @(posedge clk_i) begin
        if (rst_i) begin
            esr_o <= `SRH_W8_ZERO;
        end else begin
            esr_o <= (esr_rd_i ? `SRH_W8_ZERO : esr_o) | std_event_i;
        end
    end
    assign esb_sum = |(esr_o & ese_o);

    // lower level sticky event registers
    srh_event_reg #(.WIDTH(WIDTH)) u_dev (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(device_condition_status_o),
        .enable_i(dev_en_o),
        .rd_clr_i(dev_rd_i),
        .event_o(dev_event_o),
        .summary_o(dev_sum)
    );
    srh_event_reg #(.WIDTH(WIDTH)) u_ques (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(ques_cond_i),
        .enable_i(ques_en_o),
        .rd_clr_i(ques_rd_i),
        .event_o(ques_event_o),
        .summary_o(ques_sum)
    );
    srh_event_reg #(.WIDTH(WIDTH)) u_oper (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(oper_cond_i),
        .enable_i(oper_en_o),
        .rd_clr_i(oper_rd_i),
        .event_o(oper_event_o),
        .summary_o(oper_sum)
    );

    // status byte assembly; bit 6 never feeds its own comparison
    always @* begin
        other_bits = `SRH_W8_ZERO;
        other_bits[`SRH_STB_DEV] = dev_sum;
        other_bits[`SRH_STB_ERRQ] = err_queue_not_empty_i;
        other_bits[`SRH_STB_QUES] = ques_sum;
        other_bits[`SRH_STB_MAV] = msg_avail_i;
        other_bits[`SRH_STB_ESB] = esb_sum;
        other_bits[`SRH_STB_OPER] = oper_sum;
        stb_nxt = other_bits;
        stb_nxt[`SRH_STB_RQS] = |(other_bits & sre_o & `SRH_RQS_MASK);
    end

    // registered status byte and request; request pulses on each new source
    // so that every queued error gets its own request, not one per burst
    always @(posedge clk_i) begin
        if (rst_i) begin
            status_byte_o <= `SRH_W8_ZERO;
            srq_src_r <= `SRH_W8_ZERO;
            errq_push_r <= 1'b0;
            srq_o <= 1'b0;
        end else begin
            status_byte_o <= stb_nxt;
            srq_src_r <= other_bits & sre_o & `SRH_RQS_MASK;
            errq_push_r <= err_queue_push_i & sre_o[`SRH_STB_ERRQ];
            srq_o <= (|(other_bits & sre_o & `SRH_RQS_MASK & ~srq_src_r))
                     | errq_push_r;
        end
    end

    // indicator flashing for warning and critical categories
    srh_led_flash #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_led (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .warn_i(static_error_warn_i),
        .crit_i(static_error_crit_i),
        .red_o(led_red_o)
    );
endmodule // srh_status_top
`default_nettype wire

// File: tb/srh_host_model.sv
// Purpose: host side model that writes enable masks and reads event registers
// Assumes: strobes change just after a rising edge of clk_i
// Notes: data lines show the inverse once a write is over, never a held value
`timescale 1ns/100ps
`default_nettype none
module srh_host_model (
    // clock
    input wire logic clk_i,
    // command strobes to the device
    output logic [4:0] wr_o,
    output logic [3:0] rd_o,
    output logic [15:0] data_o
);
    initial begin
        wr_o = 5'h00;
        rd_o = 4'h0;
        data_o = 16'h0000;
    end
    // one mask write: 0 sre, 1 ese, 2 dev, 3 ques, 4 oper
    task automatic wr(input int s, input logic [15:0] d);
        @(posedge clk_i);
        wr_o <= 5'h01 << s;
        data_o <= d;
        @(posedge clk_i);
        wr_o <= 5'h00;
        data_o <= ~d;
    endtask
    // one event read, clears it: 0 dev, 1 ques, 2 oper, 3 esr
    task automatic rd(input int s);
        @(posedge clk_i);
        rd_o <= 4'h1 << s;
        @(posedge clk_i);
        rd_o <= 4'h0;
    endtask
endmodule // srh_host_model
`default_nettype wire

// File: tb/srh_status_assertions.sv
// Purpose: port checks of the status reporting top
// Assumes: one clock, synchronous active high reset
// Notes: summary bits lag their sources by one clock
`timescale 1ns/100ps
`default_nettype none
module srh_status_chk #(parameter WIDTH = 16) (
    // clock, reset and inputs
    input wire logic clk_i, rst_i, err_queue_push_i, err_queue_not_empty_i, msg_avail_i, sre_wr_i, ese_wr_i,
    input wire logic ques_rd_i, static_error_nomeas_i, static_error_badres_i, static_error_warn_i, static_error_crit_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // outputs
    input wire logic [7:0] status_byte_o, sre_o, ese_o, esr_o,
    input wire logic [WIDTH-1:0] ques_en_o, oper_en_o, device_condition_status_o, ques_event_o, oper_event_o,
    input wire logic srq_o, led_red_o
);
    // every check sleeps through reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_errq_bit: assert property (##1 status_byte_o[2] == $past(err_queue_not_empty_i))
        else $error("error queue bit wrong");
    a_mav_bit: assert property (##1 status_byte_o[4] == $past(msg_avail_i))
        else $error("message bit wrong");
    a_ques_sum: assert property (##1 status_byte_o[3] == $past(|(ques_event_o & ques_en_o)))
        else $error("questionable summary wrong");
    a_oper_sum: assert property (##1 status_byte_o[7] == $past(|(oper_event_o & oper_en_o)))
        else $error("operation summary wrong");
    a_std_sum: assert property (##1 status_byte_o[5] == $past(|(esr_o & ese_o)))
        else $error("standard event summary wrong");
    // bit 6 never enables itself
    a_rqs_sum: assert property ($stable(sre_o) |-> status_byte_o[6] == |(status_byte_o & sre_o & 8'hbf))
        else $error("request summary wrong");
    a_dev_bits: assert property (device_condition_status_o[4:0] == {static_error_crit_i, static_error_warn_i,
        static_error_badres_i, static_error_nomeas_i, static_error_crit_i | static_error_warn_i |
        static_error_badres_i | static_error_nomeas_i}) else $error("device static bits wrong");
    a_sre_write: assert property (sre_wr_i |=> sre_o == $past(wr_data_i[7:0]))
        else $error("request mask write lost");
    a_ese_write: assert property (ese_wr_i |=> ese_o == $past(ese_wr_i ? wr_data_i[7:0] : ese_o))
        else $error("event mask write lost");
    // the push is registered once before it reaches the request flop
    a_srq_push: assert property (err_queue_push_i && sre_o[2] |=> ##1 srq_o)
        else $error("no request for queue entry");
    a_event_hold: assert property (!ques_rd_i |=> (ques_event_o & $past(ques_event_o)) == $past(ques_event_o))
        else $error("event bit dropped");
    a_led_quiet: assert property (led_red_o |-> $past(static_error_warn_i | static_error_crit_i))
        else $error("indicator on without error");
    c_srq: cover property (srq_o);
    c_led: cover property (led_red_o);
    c_ques: cover property (status_byte_o[3]);
endmodule // srh_status_chk
bind srh_status_top srh_status_chk #(.WIDTH(WIDTH)) u_chk (.clk_i, .rst_i, .err_queue_push_i,
    .err_queue_not_empty_i, .msg_avail_i, .sre_wr_i, .ese_wr_i, .ques_rd_i, .static_error_nomeas_i,
    .static_error_badres_i, .static_error_warn_i, .static_error_crit_i, .wr_data_i, .status_byte_o, .sre_o,
    .ese_o, .esr_o, .ques_en_o, .oper_en_o, .device_condition_status_o, .ques_event_o, .oper_event_o,
    .srq_o, .led_red_o);
`default_nettype wire

// File: tb/srh_status_top_tb.sv
// Purpose: self-checking bench of the status reporting top
// Assumes: flash half periods shortened to 8 and 2 clocks
// Notes: host strobes come from the host model
`timescale 1ns/100ps
`default_nettype none
module srh_status_top_tb;
    logic clk_i, rst_i, push, ne, msg, led_q;
    logic [3:0] se;
    logic [7:0] std;
    logic [15:0] cnd [3];
    wire [15:0] ev [3];
    wire [7:0] sb, sre, ese, esr;
    wire [15:0] dcs, wd;
    wire [4:0] wr;
    wire [3:0] rd;
    wire srq, led;
    int mismatches = 0, cmp_count = 0, cyc = 0, nsrq = 0, ntg = 0, n, e;
    int sbit [3] = '{1, 3, 7};
    srh_host_model host (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .data_o(wd));
    srh_status_top #(.WIDTH(16), .SLOW_CYC(8), .FAST_CYC(2)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .static_error_nomeas_i(se[0]), .static_error_badres_i(se[1]), .static_error_warn_i(se[2]),
        .static_error_crit_i(se[3]), .dev_cond_hi_i(cnd[0]), .ques_cond_i(cnd[1]), .oper_cond_i(cnd[2]),
        .std_event_i(std), .err_queue_push_i(push), .err_queue_not_empty_i(ne), .msg_avail_i(msg),
        .sre_wr_i(wr[0]), .ese_wr_i(wr[1]), .dev_en_wr_i(wr[2]), .ques_en_wr_i(wr[3]), .oper_en_wr_i(wr[4]),
        .wr_data_i(wd), .dev_rd_i(rd[0]), .ques_rd_i(rd[1]), .oper_rd_i(rd[2]), .esr_rd_i(rd[3]),
        .status_byte_o(sb), .sre_o(sre), .ese_o(ese), .esr_o(esr), .dev_en_o(), .ques_en_o(), .oper_en_o(),
        .device_condition_status_o(dcs), .dev_event_o(ev[0]), .ques_event_o(ev[1]), .oper_event_o(ev[2]),
        .srq_o(srq), .led_red_o(led));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        cmp_count++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // sample well after the edge so its updates have landed
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    // request pulses, indicator toggles and the hang limit
    always @(posedge clk_i) begin
        cyc++;
        led_q <= led;
        if (srq === 1'b1) nsrq++;
        if (led !== led_q) ntg++;
        if (cyc == 5000) begin
            mismatches++;
            finish_test;
        end
    end
    initial begin
        rst_i = 1'b1;
        {push, ne, msg, se, std} = '0;
        foreach (cnd[k]) cnd[k] = 16'h0000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        step(1);
        chk(sb, 16'h0000);
        host.wr(0, 16'hffff);
        step(1);
        chk(sre, 16'h00ff);
        host.wr(1, 16'h00a5);
        step(1);
        chk(ese, 16'h00a5);
        host.wr(0, 16'h0004);
        @(posedge clk_i);
        push <= 1'b1;
        ne <= 1'b1;
        @(posedge clk_i);
        push <= 1'b0;
        step(3);
        chk(sb, 16'h0044);
        n = nsrq;
        @(posedge clk_i);
        push <= 1'b1;
        @(posedge clk_i);
        push <= 1'b0;
        step(3);
        chk(nsrq - n, 16'h0001);
        host.wr(0, 16'h0040);
        step(2);
        chk(sb, 16'h0004);
        @(posedge clk_i);
        ne <= 1'b0;
        msg <= 1'b1;
        host.wr(0, 16'h0010);
        step(2);
        chk(sb, 16'h0050);
        msg <= 1'b0;
        host.wr(0, 16'h0000);
        // a held condition must not re-arm after its read
        for (int k = 0; k < 3; k++) begin
            host.wr(k + 2, 16'h0020);
            @(posedge clk_i);
            cnd[k] <= 16'h0020;
            step(2);
            chk(ev[k], 16'h0020);
            chk(sb, 16'h0001 << sbit[k]);
            host.rd(k);
            step(1);
            chk(ev[k], 16'h0000);
            @(posedge clk_i);
            cnd[k] <= 16'h0000;
        end
        host.wr(1, 16'h0001);
        @(posedge clk_i);
        std <= 8'h01;
        @(posedge clk_i);
        std <= 8'h00;
        step(2);
        chk(esr, 16'h0001);
        chk(sb, 16'h0020);
        host.rd(3);
        step(1);
        chk(esr, 16'h0000);
        // one static error category at a time; flash rate counted over 64 clocks
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            se <= 4'h1 << i;
            step(1);
            chk(dcs[4:0], {se, 1'b1});
            e = (i == 3) ? 32 : 8;
            n = ntg;
            step(64);
            if (i >= 2) begin
                chk((ntg - n) inside {[e - 1:e + 1]}, 16'h0001);
            end else begin
                chk(ntg - n, 16'h0000);
            end
        end
        finish_test;
    end
endmodule // srh_status_top_tb
`default_nettype wire
